// ===== rtl/psc_prescaler_port.sv
/*
 prescaler divider chain, prescaler ticks and input port debounce, edge and irq flag logic,
 with an axi4-lite register slave.
 assumes ref_clk is the fast logic clock; the system clock arrives as the enable sysTickEn,
 one ref_clk cycle per system clock period; pins are asynchronous and are synchronised here.
*/
// Local design decisions: the address map and the AXI4-Lite register port.
// What this block does
// - fifteen-stage binary divider, taps 16 to 1
// - power-on loads divider with value one
// - divider clear clears taps 14..2, sets 1
// - tick source picks tap 4 or 6
// - debounce clock tap 8, else 11 or 14
// - fast tick irq on chosen tap rise
// - one second irq on tap 1 rise
// - blink irq at three quarters of second
// - reset makes no irq; first second later
// - divider stops in sleep mode
// - taps 16, 11, 1 and pwm onto outputs
// - per-bit edge, debounce, pull; levels readable
// - debounced input high after two debounce clock edges, low after one
// - irq on chosen edge, debounced or direct
// - own mask per bit, masked after reset
// - only edges after unmasking are stored
// - edge select change can make an edge
// - sleep turns input pulls off unless sleep reset option
// - bits 3 and 0 clock event counter, 3 gates ms
// - edge select zero positive, one negative
// - debounce disable zero debounced, one direct
// - mask zero blocks storing new requests
// - write one clears flag, resets to zero
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_prescaler_port import psc_pkg::*; #(
   parameter bit DEBOUNCE_FAST_TAP14 = 1'b0,
   parameter int PORT_WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerOnReset,
   input wire logic clkEn,
   input wire logic sysTickEn,
   input wire logic sleepMode,
   input wire logic pulseWidthSignal,
   input wire logic [PORT_WIDTH-1:0] inputPortPin,
   output logic [PORT_WIDTH-1:0] inputPullEnable,
   output logic [PORT_WIDTH-1:0] inputPortLevel,
   output logic eventCounterClock0,
   output logic eventCounterClock3,
   output logic millisecondCounterGate,
   output logic sleepResetWake,
   output logic [3:0] generalIoPortOut,
   output logic [3:0] generalIoPortOutEnable_n,
   output psc_tick_irq_t tickIrq,
   output logic inputIrqRequest,
   output logic [14:0] dividerTap,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   initial begin
      if (PORT_WIDTH != 4) $error("port logic serves exactly four input bits");
   end

   logic [14:0] divider;
   logic [3:0] prescalerControl;
   logic [3:0] inputIrqMask, inputIrqFlags, inputEdgeSelect, inputDebounceDisable, inputNoPull;
   logic [1:0] functionOption;
   logic [7:0] resetCombo;
   logic [3:0] pinSync1, pinSync2, debState, debSample, qualified, qualifiedPrev;
   logic [14:0] dividerPrev;
   logic debClkPrev, fastPrevSel;
   logic dividerClearPulse;
   logic [3:0] flagClear;
   logic [3:0] active;
   logic chainRun, fastTap, debClk, debRise, sleepInputsOn;
   psc_wr_state_t wrState;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic awHeld, wHeld;

   // system clock enable gated by sleep: the oscillator is stopped in sleep
   assign chainRun = clkEn && sysTickEn && !sleepMode;
   assign dividerTap = divider;

   // divider chain: bit i is tap 16-(i+1); bit 14 is tap 1
   always_ff @(posedge ref_clk) begin
      if (powerOnReset) begin
         divider <= `PSC_DIVIDER_POWER_ON;
      end else if (clkEn && dividerClearPulse) begin
         divider <= 15'h4000; // taps 14..2 cleared, tap 1 set
      end else if (chainRun) begin
         divider <= divider + 15'h0001;
      end
   end

   // tap k lives at divider bit 15-k
   function automatic logic tapOf(input logic [14:0] d, input int k);
      tapOf = d[15-k];
   endfunction

   assign fastTap = prescalerControl[`PSC_BIT_TICK_SOURCE_SELECT] ?
                    tapOf(divider, `PSC_TAP_FAST_32HZ) : tapOf(divider, `PSC_TAP_FAST_8HZ);
   // the fast tap is a build-time choice, 11 or 14
   assign debClk = prescalerControl[`PSC_BIT_DEBOUNCE_CLOCK_SELECT] ?
                   (DEBOUNCE_FAST_TAP14 ? tapOf(divider, 14) : tapOf(divider, 11)) :
                   tapOf(divider, `PSC_TAP_DEBOUNCE_SLOW);

   // edge history; reset loads the current taps so reset itself gives no edge
   always_ff @(posedge ref_clk) begin
      if (powerOnReset) begin
         dividerPrev <= `PSC_DIVIDER_POWER_ON;
         fastPrevSel <= 1'b1;
         debClkPrev <= 1'b0;
      end else if (reset) begin
         // system reset leaves the divider running, so the history follows it
         dividerPrev <= divider;
         fastPrevSel <= fastTap;
         debClkPrev <= debClk;
      end else if (clkEn) begin
         dividerPrev <= divider;
         fastPrevSel <= fastTap;
         debClkPrev <= debClk;
      end
   end

   // prescaler ticks: one ref_clk pulse each; source switch may glitch, software masks it
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         tickIrq <= '0;
      end else if (clkEn) begin
         tickIrq.fastTickIrq <= fastTap && !fastPrevSel;
         tickIrq.oneSecondIrq <= divider[14] && !dividerPrev[14];
         // three quarters through the tap 1 period: tap 1 high and tap 2 rising
         tickIrq.blinkIrq <= divider[14] && divider[13] && !dividerPrev[13];
      end else begin
         tickIrq <= '0;
      end
   end

   // clock outputs onto the general i/o port; pins driven while enable_n low
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         generalIoPortOut <= 4'h0;
         generalIoPortOutEnable_n <= 4'hf;
      end else if (clkEn) begin
         generalIoPortOut <= {pulseWidthSignal, sysTickEn, tapOf(divider, 11), divider[14]};
         generalIoPortOutEnable_n <= {!prescalerControl[`PSC_BIT_PULSE_WIDTH_OUTPUT_ON],
                                      {3{!functionOption[`PSC_BIT_CLOCK_OUT_ENABLE]}}};
      end
   end

   // pin synchroniser; the first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         pinSync1 <= 4'h0;
         pinSync2 <= 4'h0;
      end else if (clkEn) begin
         pinSync1 <= inputPortPin;
         pinSync2 <= pinSync1;
      end
   end

   // in sleep the input pulls are cut unless the sleep reset option keeps them on for the wake check
   assign sleepInputsOn = !sleepMode || functionOption[`PSC_BIT_SLEEP_INPUT_RESET_ENABLE];
   assign inputPullEnable = sleepInputsOn ? ~inputNoPull : 4'h0;
   assign debRise = debClk && !debClkPrev;

   // debouncer: a high is taken once it held over two debounce clock rises, a low at the first rise that samples it
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         debSample <= 4'h0;
         debState <= 4'h0;
      end else if (clkEn && debRise) begin
         debSample <= pinSync2;
         debState <= (debSample & pinSync2) | (debState & ~(debSample ^ pinSync2));
      end
   end

   // source per bit, then inversion for negative edge so a rise is always the active edge
   assign qualified = ((inputDebounceDisable & pinSync2) | (~inputDebounceDisable & debState))
                      ^ inputEdgeSelect;
   assign active = qualified & ~qualifiedPrev;
   assign inputPortLevel = pinSync2;
   assign eventCounterClock0 = qualified[0];
   assign eventCounterClock3 = qualified[3];
   assign millisecondCounterGate = pinSync2[3];

   // sleep reset combination: per bit 00 never, 01 level, 10 inverted, 11 don't care
   always_comb begin
      sleepResetWake = sleepMode && functionOption[`PSC_BIT_SLEEP_INPUT_RESET_ENABLE];
      for (int n = 0; n < 4; n++) begin
         case ({resetCombo[n], resetCombo[n+4]})
            2'b00: sleepResetWake = 1'b0;
            2'b01: sleepResetWake = sleepResetWake && pinSync2[n];
            2'b10: sleepResetWake = sleepResetWake && !pinSync2[n];
            default: sleepResetWake = sleepResetWake;
         endcase
      end
   end

   // edge history for the port; reset loads zero
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         qualifiedPrev <= 4'h0;
      end else if (clkEn) begin
         qualifiedPrev <= qualified;
      end
   end

   // irq flags: set wins over a same-cycle clear; masked bits store nothing new
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         inputIrqFlags <= 4'h0;
      end else if (clkEn) begin
         inputIrqFlags <= (inputIrqFlags & ~flagClear) | (active & inputIrqMask);
      end
   end
   assign inputIrqRequest = |inputIrqFlags;

   // register writes
   logic wrFire;
   assign wrFire = clkEn && (wrState == PSC_WR_IDLE) && awHeld && wHeld;
   assign dividerClearPulse = wrFire && wrAddr == `PSC_ADDR_PRESCALER_CONTROL && wrData[`PSC_BIT_DIVIDER_CLEAR];
   assign flagClear = (wrFire && wrAddr == `PSC_ADDR_INPUT_IRQ_FLAGS) ? wrData[3:0] : 4'h0;

   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         prescalerControl <= `PSC_CONTROL_RESET;
         inputIrqMask <= `PSC_MASK_RESET;
      end else if (wrFire) begin
         if (wrAddr == `PSC_ADDR_PRESCALER_CONTROL) begin
            prescalerControl <= {wrData[3], 1'b0, wrData[1:0]};
         end
         if (wrAddr == `PSC_ADDR_INPUT_IRQ_MASK) begin
            inputIrqMask <= wrData[3:0];
         end
      end
   end

   // option registers survive system reset, only power-on clears them
   always_ff @(posedge ref_clk) begin
      if (powerOnReset) begin
         inputEdgeSelect <= 4'h0;
         inputDebounceDisable <= 4'h0;
         inputNoPull <= 4'h0;
         functionOption <= 2'h0;
         resetCombo <= 8'h00;
      end else if (wrFire) begin
         case (wrAddr)
            `PSC_ADDR_INPUT_EDGE_SELECT: inputEdgeSelect <= wrData[3:0];
            `PSC_ADDR_INPUT_DEBOUNCE_DISABLE: inputDebounceDisable <= wrData[3:0];
            `PSC_ADDR_INPUT_NO_PULL: inputNoPull <= wrData[3:0];
            `PSC_ADDR_FUNCTION_OPTION: functionOption <= wrData[1:0];
            `PSC_ADDR_RESET_COMBO: resetCombo <= wrData[7:0];
            default: ;
         endcase
      end
   end

   // axi write channels: address and data held independently, response after both
   assign s_axi_awready = !awHeld && wrState == PSC_WR_IDLE;
   assign s_axi_wready = !wHeld && wrState == PSC_WR_IDLE;
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         wrState <= PSC_WR_IDLE;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PSC_RESP_OKAY;
      end else if (clkEn) begin
         case (wrState)
            PSC_WR_IDLE: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  awHeld <= 1'b1;
                  wrAddr <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wHeld <= 1'b1;
                  wrData <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0; // only the low lane holds fields
               end
               if (awHeld && wHeld) begin
                  awHeld <= 1'b0;
                  wHeld <= 1'b0;
                  wrState <= PSC_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= (wrAddr > `PSC_ADDR_RESET_COMBO || wrAddr[1:0] != 2'b00 ||
                                  wrAddr == `PSC_ADDR_INPUT_PORT) ? PSC_RESP_SLVERR : PSC_RESP_OKAY;
               end
            end
            PSC_WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wrState <= PSC_WR_IDLE;
               end
            end
            default: wrState <= PSC_WR_IDLE;
         endcase
      end
   end

   // axi read: one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge ref_clk) begin
      if (reset || powerOnReset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= PSC_RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= PSC_RESP_OKAY;
            case (s_axi_araddr)
               `PSC_ADDR_PRESCALER_CONTROL: s_axi_rdata <= {28'h0, prescalerControl}; // clear bit reads 0
               `PSC_ADDR_INPUT_PORT: s_axi_rdata <= {28'h0, pinSync2};
               `PSC_ADDR_INPUT_IRQ_MASK: s_axi_rdata <= {28'h0, inputIrqMask};
               `PSC_ADDR_INPUT_IRQ_FLAGS: s_axi_rdata <= {28'h0, inputIrqFlags};
               `PSC_ADDR_INPUT_EDGE_SELECT: s_axi_rdata <= {28'h0, inputEdgeSelect};
               `PSC_ADDR_INPUT_DEBOUNCE_DISABLE: s_axi_rdata <= {28'h0, inputDebounceDisable};
               `PSC_ADDR_INPUT_NO_PULL: s_axi_rdata <= {28'h0, inputNoPull};
               `PSC_ADDR_FUNCTION_OPTION: s_axi_rdata <= {30'h0, functionOption};
               `PSC_ADDR_RESET_COMBO: s_axi_rdata <= {24'h0, resetCombo};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= PSC_RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

// ===== rtl/psc_defines.svh
/*
 prescaler and input port block: register offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from the design module.
*/
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_ADDR_PRESCALER_CONTROL 8'h00
`define PSC_ADDR_INPUT_PORT 8'h04
`define PSC_ADDR_INPUT_IRQ_MASK 8'h08
`define PSC_ADDR_INPUT_IRQ_FLAGS 8'h0c
`define PSC_ADDR_INPUT_EDGE_SELECT 8'h10
`define PSC_ADDR_INPUT_DEBOUNCE_DISABLE 8'h14
`define PSC_ADDR_INPUT_NO_PULL 8'h18
`define PSC_ADDR_FUNCTION_OPTION 8'h1c
`define PSC_ADDR_RESET_COMBO 8'h20
`define PSC_BIT_DEBOUNCE_CLOCK_SELECT 0
`define PSC_BIT_TICK_SOURCE_SELECT 1
`define PSC_BIT_DIVIDER_CLEAR 2
`define PSC_BIT_PULSE_WIDTH_OUTPUT_ON 3
`define PSC_BIT_SLEEP_INPUT_RESET_ENABLE 0
`define PSC_BIT_CLOCK_OUT_ENABLE 1
`define PSC_DIVIDER_POWER_ON 15'h0001
`define PSC_CONTROL_RESET 4'h0
`define PSC_MASK_RESET 4'h0
`define PSC_TAP_FAST_8HZ 4
`define PSC_TAP_FAST_32HZ 6
`define PSC_TAP_DEBOUNCE_SLOW 8
`define PSC_TAP_ONE_SECOND 1
`define PSC_SYSTEM_CLOCK_HZ 32768
`define PSC_REF_CLOCK_HZ 50000000
`endif

// ===== rtl/psc_pkg.sv
/*
 types shared by the prescaler and input port block.
 assumes the defines header sits beside it in rtl/.
*/
package psc_pkg;
   // prescaler interrupt pulses toward the cpu interrupt logic
   typedef struct packed {
      logic fastTickIrq;
      logic oneSecondIrq;
      logic blinkIrq;
   } psc_tick_irq_t;
   // register bus response codes
   typedef enum logic [1:0] {
      PSC_RESP_OKAY = 2'b00,
      PSC_RESP_SLVERR = 2'b10
   } psc_resp_t;
   // write path states
   typedef enum logic [1:0] {
      PSC_WR_IDLE = 2'b00,
      PSC_WR_RESP = 2'b01
   } psc_wr_state_t;
endpackage

// ===== bench/psc_prescaler_port_properties.sv
/*
 port assertions for the prescaler and input port block.
 assumes a bind onto psc_prescaler_port and one ref_clk domain.
*/
`timescale 1ns/1ps
module psc_prescaler_port_properties import psc_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerOnReset,
   input wire logic clkEn,
   input wire logic sysTickEn,
   input wire logic sleepMode,
   input wire logic pulseWidthSignal,
   input wire logic sleepResetWake,
   input wire logic [3:0] generalIoPortOut,
   input wire psc_tick_irq_t tickIrq,
   input wire logic [14:0] dividerTap,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset || powerOnReset);
   // a clear may land instead of the step, so a value with taps 14..2 low is accepted too
   property p_div_count;
      sysTickEn && clkEn && !sleepMode |=> dividerTap == $past(dividerTap) + 15'h1 || dividerTap[13:1] == 13'h0;
   endproperty
   property p_div_por;
      disable iff (reset) powerOnReset |=> dividerTap == 15'h0001;
   endproperty
   property p_div_sleep;
      sleepMode |=> $stable(dividerTap);
   endproperty
   // clkEn low forces the pulses off, so a freeze excuses a missing pulse
   property p_sec;
      $rose(dividerTap[14]) && clkEn |-> ##[0:1] (tickIrq.oneSecondIrq || !clkEn);
   endproperty
   property p_blink;
      tickIrq.blinkIrq |-> dividerTap[14:13] == 2'b11;
   endproperty
   property p_fast;
      tickIrq.fastTickIrq |-> dividerTap[11] || dividerTap[9];
   endproperty
   property p_pulse;
      |tickIrq |=> (tickIrq & $past(tickIrq)) == 3'b000;
   endproperty
   property p_wake;
      sleepResetWake |-> sleepMode;
   endproperty
   property p_ports;
      !$past(reset) && !$past(powerOnReset) && $past(clkEn) && !$past(sleepMode) |->
         generalIoPortOut == $past({pulseWidthSignal, sysTickEn, dividerTap[4], dividerTap[14]});
   endproperty
   property p_bresp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_div_count: assert property (p_div_count) else $error("divider did not step");
   a_div_por: assert property (p_div_por) else $error("divider not one after power on");
   a_div_sleep: assert property (p_div_sleep) else $error("divider moved in sleep");
   a_sec: assert property (p_sec) else $error("one second pulse missing");
   a_blink: assert property (p_blink) else $error("blink pulse off phase");
   a_fast: assert property (p_fast) else $error("fast tick with both taps low");
   a_pulse: assert property (p_pulse) else $error("tick pulse longer than one cycle");
   a_wake: assert property (p_wake) else $error("wake outside sleep");
   a_ports: assert property (p_ports) else $error("port outputs wrong");
   a_bresp: assert property (p_bresp) else $error("write response late");
   a_rlat: assert property (p_rlat) else $error("read data late");
   c_sec: cover property (tickIrq.oneSecondIrq);
   c_blink: cover property (tickIrq.blinkIrq);
   c_wake: cover property (sleepResetWake);
endmodule
bind psc_prescaler_port psc_prescaler_port_properties psc_prescaler_port_properties_i (.ref_clk, .reset,
   .powerOnReset, .clkEn, .sysTickEn, .sleepMode, .pulseWidthSignal, .sleepResetWake, .generalIoPortOut,
   .tickIrq, .dividerTap, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ===== bench/psc_irq_partner.sv
/*
 model of the system clock source and the cpu interrupt logic.
 assumes the block samples sysTickEn on ref_clk.
*/
`timescale 1ns/1ps
module psc_irq_partner import psc_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire psc_tick_irq_t tickIrq,
   output logic sysTickEn,
   output logic [15:0] fastCount,
   output logic [15:0] secCount,
   output logic [15:0] blinkCount
);
   initial sysTickEn = 1'b0;
   // one system tick per cycle keeps a second at 32768 cycles; slower rates add nothing
   always @(posedge ref_clk) begin
      sysTickEn <= !reset;
   end
   // each pulse is counted once per cycle it stands, so a long pulse shows as extra counts
   always @(posedge ref_clk) begin
      if (reset) begin
         fastCount <= 16'h0;
         secCount <= 16'h0;
         blinkCount <= 16'h0;
      end else begin
         fastCount <= fastCount + {15'h0, tickIrq.fastTickIrq};
         secCount <= secCount + {15'h0, tickIrq.oneSecondIrq};
         blinkCount <= blinkCount + {15'h0, tickIrq.blinkIrq};
      end
   end
endmodule

// ===== bench/psc_prescaler_port_tb.sv
/*
 self-checking bench for the prescaler and input port block.
 assumes the partner gives a system tick every cycle and counts prescaler pulses.
*/
`timescale 1ns/1ps
module psc_prescaler_port_tb import psc_pkg::*; ;
   logic ref_clk = 1'b0, reset = 1'b1, powerOnReset = 1'b1, clkEn = 1'b1, sleepMode = 1'b0;
   logic pulseWidthSignal = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [3:0] inputPortPin = 4'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic inputIrqRequest, sleepResetWake, sysTickEn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] inputPullEnable, inputPortLevel, generalIoPortOut, generalIoPortOutEnable_n;
   logic [14:0] dividerTap, d;
   logic [15:0] fastCount, secCount, blinkCount;
   logic [7:0] regs [8] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
   psc_tick_irq_t tickIrq;
   int fails = 0, num_checks = 0;
   psc_prescaler_port psc_prescaler_port_i (.ref_clk, .reset, .powerOnReset, .clkEn, .sysTickEn, .sleepMode,
      .pulseWidthSignal, .inputPortPin, .inputPullEnable, .inputPortLevel, .eventCounterClock0(),
      .eventCounterClock3(), .millisecondCounterGate(), .sleepResetWake, .generalIoPortOut,
      .generalIoPortOutEnable_n, .tickIrq, .inputIrqRequest, .dividerTap, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1));
   psc_irq_partner psc_irq_partner_i (.ref_clk, .reset, .tickIrq, .sysTickEn, .fastCount, .secCount,
      .blinkCount);
   always #10 ref_clk = ~ref_clk;
   // toggling pwm source so the pass-through is exercised
   always @(posedge ref_clk) pulseWidthSignal <= ~pulseWidthSignal;
   task automatic check(input logic [31:0] seen, input logic [31:0] ex);
      num_checks++;
      if (seen !== ex) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic end_of_test;
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // bready is held high, so the edge that shows bvalid is the handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = PSC_RESP_OKAY);
      logic aw = 1'b1, w = 1'b1;
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while ((aw || w || !s_axi_bvalid) && n < 50) begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
      end
      check(32'(n < 50), 32'h1);
      check(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = PSC_RESP_OKAY);
      logic ar = 1'b1;
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while ((ar || !s_axi_rvalid) && n < 50) begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         ar = ar && !s_axi_arready;
      end
      check(32'(n < 50), 32'h1);
      check(s_axi_rdata, ex);
      check(32'(s_axi_rresp), 32'(er));
   endtask
   // one full second: a single tap 1 rise and blink, f fast ticks
   task automatic ticks(input logic [15:0] f);
      logic [15:0] f0, s0, b0;
      f0 = fastCount;
      s0 = secCount;
      b0 = blinkCount;
      cyc(32768);
      check(32'(fastCount - f0), 32'(f));
      check(32'(secCount - s0), 32'h1);
      check(32'(blinkCount - b0), 32'h1);
   endtask
   // a hang: the run is about 70k cycles, the limit is 100k
   initial begin
      #2_000_000;
      fails++;
      end_of_test();
   end
   initial begin
      cyc(2);
      reset <= 1'b0;
      powerOnReset <= 1'b0;
      cyc(2);
      check(32'(secCount), 32'h0);
      check(32'(dividerTap[14:8]), 32'h0);
      foreach (regs[i]) rd(regs[i], 32'h0);
      rd(8'h40, 32'h0, PSC_RESP_SLVERR);
      wr(8'h04, 32'h1, PSC_RESP_SLVERR);
      ticks(16'd8);
      // source switch may pulse once, so counting starts after it settles
      wr(8'h00, 32'h2);
      cyc(4);
      ticks(16'd32);
      wr(8'h00, 32'h6);
      check(32'(dividerTap[14:8]), 32'h40);
      rd(8'h00, 32'h2);
      wr(8'h00, 32'ha);
      wr(8'h1c, 32'h2);
      cyc(2);
      check(32'(generalIoPortOutEnable_n), 32'h0);
      inputPortPin <= 4'h5;
      cyc(4);
      rd(8'h04, 32'h5);
      check(32'(inputPortLevel), 32'h5);
      inputPortPin <= 4'h0;
      // bits 2..0 direct, bit 3 debounced, only bit 0 unmasked
      wr(8'h14, 32'h7);
      wr(8'h08, 32'h1);
      inputPortPin <= 4'h3;
      cyc(6);
      rd(8'h0c, 32'h1);
      check(32'(inputIrqRequest), 32'h1);
      wr(8'h08, 32'h3);
      inputPortPin <= 4'h0;
      cyc(6);
      rd(8'h0c, 32'h1);
      wr(8'h0c, 32'h1);
      rd(8'h0c, 32'h0);
      wr(8'h10, 32'h1);
      cyc(4);
      rd(8'h0c, 32'h1);
      wr(8'h0c, 32'h0);
      rd(8'h0c, 32'h1);
      wr(8'h0c, 32'hf);
      check(32'(inputIrqRequest), 32'h0);
      wr(8'h08, 32'h8);
      inputPortPin <= 4'h8;
      cyc(100);
      rd(8'h0c, 32'h0);
      cyc(700);
      rd(8'h0c, 32'h8);
      wr(8'h0c, 32'h8);
      wr(8'h10, 32'h9);
      wr(8'h00, 32'hb);
      inputPortPin <= 4'h0;
      cyc(20);
      rd(8'h0c, 32'h0);
      cyc(100);
      rd(8'h0c, 32'h8);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      cyc(2);
      rd(8'h08, 32'h0);
      rd(8'h10, 32'h9);
      // any-level combination matches at once
      wr(8'h20, 32'hff);
      wr(8'h1c, 32'h1);
      sleepMode <= 1'b1;
      cyc(3);
      check(32'(inputPullEnable), 32'hf);
      check(32'(sleepResetWake), 32'h1);
      wr(8'h1c, 32'h0);
      check(32'(inputPullEnable), 32'h0);
      check(32'(sleepResetWake), 32'h0);
      sleepMode <= 1'b0;
      clkEn <= 1'b0;
      cyc(2);
      d = dividerTap;
      cyc(5);
      check(32'(dividerTap), 32'(d));
      clkEn <= 1'b1;
      powerOnReset <= 1'b1;
      cyc(1);
      powerOnReset <= 1'b0;
      cyc(2);
      rd(8'h10, 32'h0);
      end_of_test();
   end
endmodule
